// ---- src/lbrs_top.sv ----
// Module: logic block distributed RAM and storage elements
`timescale 1ns/1ps
// Operation
// RULE_01: Basic mode holds sixteen bits selected by one four-bit address.
// RULE_02: Single-port mode has one data input and one output at the address.
// RULE_03: Paired mode gives two independent sixteen-bit arrays with own addresses.
// RULE_04: Paired arrays share write enable and write clock, writing on one edge.
// RULE_05: Deep mode has thirty-two bits; upper address bit from third input.
// RULE_06: Dual-port mode: write/read port plus independent read-only port.
// RULE_07: Dual-port reads and writes together; single-port does one operation.
// RULE_08: Write on active write-clock edge while enable high; inputs held stable.
// RULE_09: Edge captures address, data, enable; internal pulse stores the bit.
// RULE_10: Two flip-flops share clock, clock enable and set/reset.
// RULE_11: Direct input or third generator input may feed either flip-flop.
// RULE_12: Global init forces both flip-flops to initial state.
// RULE_13: Storage elements may act as latches with shared gate and enable.
// RULE_14: At most two unregistered outputs; a third function is registered.
// RULE_15: RAM reads are combinational; writes are edge-triggered.
// RULE_16: Dual-port writes at primary address; second output reads second address.
// RULE_17: Global init leaves RAM contents alone; RAM starts at zeros.
// RULE_18: Reads show a newly written bit, including coinciding dual-port addresses.
module lbrs_top #(
    parameter int DEPTH = lbrs_pkg::DEPTH_DEEP
) (
    input  wire logic                     CLK_SYS,
    input  wire logic                     RST,
    input  wire lbrs_pkg::lbrs_mode_t     RAM_MODE,
    input  wire lbrs_pkg::lbrs_wreq_t     WREQ,
    output lbrs_pkg::lbrs_rd_t            RD,
    input  wire logic                     FF_TIMING_EDGE_INPUT,
    input  wire logic                     STORAGE_ENABLE,
    input  wire logic                     SET_RESET,
    input  wire logic                     GLOBAL_INIT,
    input  wire logic                     LATCH_MODE,
    input  wire logic [1:0]               SET_RESET_VAL,
    input  wire lbrs_pkg::lbrs_src_t      SRC_SEL_A,
    input  wire lbrs_pkg::lbrs_src_t      SRC_SEL_B,
    input  wire logic                     DIRECT_IN,
    input  wire logic                     THIRD_GEN_INPUT,
    input  wire logic [1:0]               FUNC_IN,
    input  wire logic                     FUNC_THIRD,
    output logic      [1:0]               FUNC_OUT,
    output logic      [1:0]               STORE_Q
);

    localparam int AW = lbrs_pkg::ADDR_DEEP_W;

    // Write pipeline states: idle, then one-cycle internal store pulse
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_PULSE = 2'b10
    } lbrs_wst_t;

    lbrs_wst_t            st_ff;
    lbrs_wst_t            nxt_st;
    logic [DEPTH-1:0]     mem_ff;
    logic [AW-1:0]        cap_addr0_ff;
    logic [AW-1:0]        cap_addr1_ff;
    logic                 cap_d0_ff;
    logic                 cap_d1_ff;
    logic                 cap_pair_ff;
    logic [AW-1:0]        wr_addr0;
    logic [AW-1:0]        wr_addr1;
    logic                 wr_d0;
    logic                 wr_pair;
    logic [AW-1:0]        rd_addr0;
    logic [AW-1:0]        rd_addr1;
    logic                 third_fn;
    logic [1:0]           store_d;

    // Maps a mode and 4-bit address onto the physical 32-bit array
    function automatic logic [AW-1:0] map_addr(input lbrs_pkg::lbrs_mode_t m,
                                               input logic [3:0] a,
                                               input logic hi,
                                               input logic upper_half);
        logic [AW-1:0] r;
        r = {1'h0, a};
        unique case (m)
            lbrs_pkg::MODE_SP16:   r = {1'h0, a}; // [RULE_01]
            lbrs_pkg::MODE_SP16X2: r = {upper_half, a}; // [RULE_03]
            lbrs_pkg::MODE_SP32:   r = {hi, a}; // [RULE_05]
            lbrs_pkg::MODE_DP16:   r = {upper_half, a}; // [RULE_06]
        endcase
        return r;
    endfunction

    // Port zero always uses the primary address; port one depends on mode
    assign wr_addr0 = map_addr(RAM_MODE, WREQ.addr_a, WREQ.upper_address_bit, 1'h0);
    // Dual port mirrors writes into the upper copy at the same primary address
    assign wr_addr1 = (RAM_MODE == lbrs_pkg::MODE_DP16)
                      ? map_addr(RAM_MODE, WREQ.addr_a, 1'h0, 1'h1) // [RULE_16]
                      : map_addr(RAM_MODE, WREQ.addr_b, 1'h0, 1'h1); // [RULE_03]
    assign wr_d0    = WREQ.data_in_zero; // [RULE_02]
    assign wr_pair  = (RAM_MODE == lbrs_pkg::MODE_SP16X2) ||
                      (RAM_MODE == lbrs_pkg::MODE_DP16); // [RULE_04]

    // Write FSM: capture on the edge, store on the pulse cycle that follows
    always_comb begin
        // A request is taken whenever enable is high at the edge, in any mode
        nxt_st = WREQ.we ? ST_PULSE : ST_IDLE; // [RULE_08]
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_ff <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Capture register; only loaded while enable is high at the edge
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cap_addr0_ff <= '0;
            cap_addr1_ff <= '0;
            cap_d0_ff    <= 1'h0;
            cap_d1_ff    <= 1'h0;
            cap_pair_ff  <= 1'h0;
        end else if (WREQ.we) begin
            cap_addr0_ff <= wr_addr0; // [RULE_09]
            cap_addr1_ff <= wr_addr1;
            cap_d0_ff    <= wr_d0;
            cap_d1_ff    <= (RAM_MODE == lbrs_pkg::MODE_DP16)
                            ? wr_d0 : WREQ.data_in_one;
            cap_pair_ff  <= wr_pair;
        end
    end

    // Storage cells; reset is not wired here so init never clears contents
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_cell
            // Power-up value stands in for configuration-time loading; a plain
            // clocked process is used so the start value and the writes may share the bit
            initial mem_ff[i] = lbrs_pkg::RAM_INIT_BIT; // [RULE_17]
            always @(posedge CLK_SYS) begin
                if (st_ff == ST_PULSE && cap_addr0_ff == AW'(i)) begin
                    mem_ff[i] <= cap_d0_ff; // [RULE_09]
                end else if (st_ff == ST_PULSE && cap_pair_ff &&
                             cap_addr1_ff == AW'(i)) begin
                    mem_ff[i] <= cap_d1_ff; // [RULE_04]
                end
            end
        end
    endgenerate

    // Combinational reads straight from the cells; no read clock involved
    assign rd_addr0 = wr_addr0;
    assign rd_addr1 = (RAM_MODE == lbrs_pkg::MODE_DP16)
                      ? map_addr(RAM_MODE, WREQ.addr_b, 1'h0, 1'h1) // [RULE_16]
                      : wr_addr1;
    assign RD.primary_read_out   = mem_ff[rd_addr0]; // [RULE_15]
    assign RD.second_read_output = wr_pair ? mem_ff[rd_addr1] : 1'h0; // [RULE_07] [RULE_18]

    // Third generator output; it may only go to storage, since FUNC_OUT carries the other two
    assign third_fn  = FUNC_THIRD ^ THIRD_GEN_INPUT;
    assign FUNC_OUT  = FUNC_IN; // [RULE_14]

    // Per-element data source select
    assign store_d[0] = (SRC_SEL_A == lbrs_pkg::SRC_DIRECT) ? DIRECT_IN :
                        (SRC_SEL_A == lbrs_pkg::SRC_THIRD)  ? third_fn  :
                        FUNC_IN[0]; // [RULE_11]
    assign store_d[1] = (SRC_SEL_B == lbrs_pkg::SRC_DIRECT) ? DIRECT_IN :
                        (SRC_SEL_B == lbrs_pkg::SRC_THIRD)  ? third_fn  :
                        FUNC_IN[1]; // [RULE_11]

    lbrs_store u_store (
        .ff_timing_edge_input (FF_TIMING_EDGE_INPUT),
        .rst                  (RST),
        .global_init          (GLOBAL_INIT),
        .storage_enable       (STORAGE_ENABLE),
        .set_reset            (SET_RESET),
        .latch_mode           (LATCH_MODE),
        .set_reset_val        (SET_RESET_VAL),
        .d_in                 (store_d),
        .q_out                (STORE_Q)
    );

endmodule

// ---- shared/lbrs_pkg.sv ----
// Package: shared constants and carrier types for the logic block storage
package lbrs_pkg;

    // Geometry of the distributed RAM
    localparam int DEPTH_SHALLOW = 16;
    localparam int DEPTH_DEEP    = 32;
    localparam int ADDR_W        = 4;
    localparam int ADDR_DEEP_W   = 5;

    // Reset and initial values
    localparam logic RAM_INIT_BIT = 1'h0;
    localparam logic FF_INIT_BIT  = 1'h0;

    // RAM configuration modes
    typedef enum logic [1:0] {
        MODE_SP16   = 2'h0,
        MODE_SP16X2 = 2'h1,
        MODE_SP32   = 2'h2,
        MODE_DP16   = 2'h3
    } lbrs_mode_t;

    // Source select for each storage element
    typedef enum logic [1:0] {
        SRC_FUNC   = 2'h0,
        SRC_DIRECT = 2'h1,
        SRC_THIRD  = 2'h2
    } lbrs_src_t;

    // Write request from user logic
    typedef struct packed {
        logic [ADDR_W-1:0] addr_a;
        logic [ADDR_W-1:0] addr_b;
        logic              upper_address_bit;
        logic              data_in_zero;
        logic              data_in_one;
        logic              we;
    } lbrs_wreq_t;

    // Read outputs to user logic
    typedef struct packed {
        logic primary_read_out;
        logic second_read_output;
    } lbrs_rd_t;

endpackage

// ---- src/lbrs_store.sv ----
// Module: pair of storage elements, flip-flop or latch, with shared controls
`timescale 1ns/1ps
module lbrs_store (
    input  wire logic             ff_timing_edge_input,
    input  wire logic             rst,
    input  wire logic             global_init,
    input  wire logic             storage_enable,
    input  wire logic             set_reset,
    input  wire logic             latch_mode,
    input  wire logic [1:0]       set_reset_val,
    input  wire logic [1:0]       d_in,
    output logic      [1:0]       q_out
);

    logic [1:0] q_ff;
    logic [1:0] lat_q;

    // Both edge elements share clock, enable and set/reset; init overrides all
    always_ff @(posedge ff_timing_edge_input or posedge rst) begin
        if (rst) begin
            q_ff <= {2{lbrs_pkg::FF_INIT_BIT}};
        end else if (global_init) begin
            q_ff <= {2{lbrs_pkg::FF_INIT_BIT}}; // [RULE_12]
        end else if (set_reset) begin
            q_ff <= set_reset_val; // [RULE_10]
        end else if (storage_enable) begin
            q_ff <= d_in; // [RULE_10]
        end
    end

    // Level-sensitive variant; transparent while the shared gate is high
    always_latch begin
        if (rst || global_init) begin
            lat_q = {2{lbrs_pkg::FF_INIT_BIT}}; // [RULE_12]
        end else if (set_reset) begin
            lat_q = set_reset_val;
        end else if (ff_timing_edge_input && storage_enable) begin
            lat_q = d_in; // [RULE_13]
        end
    end

    assign q_out = latch_mode ? lat_q : q_ff; // [RULE_13]

endmodule

// ---- tb/lbrs_chk_assertions.sv ----
// Checker: port-level assertions for the logic block storage
`timescale 1ns/1ps
module lbrs_chk (
    input wire logic                 CLK_SYS,
    input wire logic                 RST,
    input wire lbrs_pkg::lbrs_mode_t RAM_MODE,
    input wire lbrs_pkg::lbrs_wreq_t WREQ,
    input wire lbrs_pkg::lbrs_rd_t   RD,
    input wire logic                 GLOBAL_INIT,
    input wire logic [1:0]           FUNC_IN,
    input wire logic [1:0]           FUNC_OUT,
    input wire logic [1:0]           STORE_Q
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Mode history; a mode change inside a write window voids the check
    lbrs_pkg::lbrs_mode_t m1_ff;
    lbrs_pkg::lbrs_mode_t m2_ff;
    always_ff @(posedge CLK_SYS) begin
        m1_ff <= RAM_MODE;
        m2_ff <= m1_ff;
    end
    // Short names for the request and read fields
    wire logic       held = (RAM_MODE == m1_ff) && (m1_ff == m2_ff);
    wire logic       sp16 = RAM_MODE == lbrs_pkg::MODE_SP16;
    wire logic       x2   = RAM_MODE == lbrs_pkg::MODE_SP16X2;
    wire logic       sp32 = RAM_MODE == lbrs_pkg::MODE_SP32;
    wire logic       dp   = RAM_MODE == lbrs_pkg::MODE_DP16;
    wire logic [3:0] aa   = WREQ.addr_a;
    wire logic [3:0] ab   = WREQ.addr_b;
    wire logic       hi   = WREQ.upper_address_bit;
    wire logic       d0   = WREQ.data_in_zero;
    wire logic       d1   = WREQ.data_in_one;
    wire logic       we   = WREQ.we;
    wire logic       po   = RD.primary_read_out;
    wire logic       so   = RD.second_read_output;
    a_idle_holds:
        assert property (held && sp16 && $stable(aa) && !$past(we, 2) |-> $stable(po))
        else $error("read changed without a write");
    a_sp16_lands:
        assert property (held && sp16 && $past(we, 2) && aa == $past(aa, 2) |-> po == $past(d0, 2))
        else $error("16x1 write not visible");
    a_deep_lands:
        assert property (held && sp32 && $past(we, 2) && aa == $past(aa, 2) && hi == $past(hi, 2)
            |-> po == $past(d0, 2)) else $error("32x1 write not visible");
    a_pair_lands:
        assert property (held && x2 && $past(we, 2) && ab == $past(ab, 2) |-> so == $past(d1, 2))
        else $error("second array write not visible");
    a_dual_lands:
        assert property (held && dp && $past(we, 2) && ab == $past(aa, 2) |-> so == $past(d0, 2))
        else $error("second port misses write");
    a_second_quiet:
        assert property ((sp16 || sp32) |-> !so) else $error("second output active");
    a_func_pass:
        assert property (FUNC_OUT == FUNC_IN) else $error("function output differs");
    a_init_clears:
        assert property (GLOBAL_INIT [*3] |-> STORE_Q == 2'h0) else $error("init left store set");
    c_pair_write: cover property (x2 && we);
    c_deep_write: cover property (sp32 && we && hi);
    c_dual_write: cover property (dp && we);
endmodule
bind lbrs_top lbrs_chk i_lbrs_chk (.CLK_SYS, .RST, .RAM_MODE, .WREQ, .RD, .GLOBAL_INIT,
    .FUNC_IN, .FUNC_OUT, .STORE_Q);

// ---- tb/lbrs_user.sv ----
// Partner: user logic that launches write requests off the falling edge
`timescale 1ns/1ps
module lbrs_user (
    input  wire logic                 clk,
    input  wire lbrs_pkg::lbrs_wreq_t cmd,
    output lbrs_pkg::lbrs_wreq_t      wreq
);
    lbrs_pkg::lbrs_wreq_t             idle;
    initial wreq = '0;
    // Idle data wanders off so a refused write would leave a wrong bit
    always_comb begin
        idle              = cmd;
        idle.data_in_zero = ~wreq.data_in_zero;
        idle.data_in_one  = ~wreq.data_in_one;
    end
    // Held for a full cycle around the write edge; one assignment per edge
    always @(negedge clk) begin
        wreq <= cmd.we ? cmd : idle;
    end
endmodule

// ---- tb/test_lbrs_top.sv ----
// Testbench: directed scenarios for the logic block storage
`timescale 1ns/1ps
module test_lbrs_top;
    logic                 clk = 1'h0, rst = 1'h1, ffc = 1'h0, gi = 1'h0, se = 1'h1, sr = 1'h0;
    logic                 lm = 1'h0, din = 1'h0, tgi = 1'h0, ft = 1'h0;
    logic [1:0]           srv = 2'h0, fin = 2'h0, fout, q;
    lbrs_pkg::lbrs_mode_t mode = lbrs_pkg::MODE_SP16;
    lbrs_pkg::lbrs_src_t  sa = lbrs_pkg::SRC_DIRECT, sb = lbrs_pkg::SRC_THIRD;
    lbrs_pkg::lbrs_wreq_t cmd = '0, wreq;
    lbrs_pkg::lbrs_rd_t   rd;
    int                   bad_count = 0, total_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    // Storage clock free-runs at half rate so each wait of four cycles sees an edge
    always @(negedge clk) ffc <= ~ffc;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            print_verdict();
        end
    end
    lbrs_user i_lbrs_user (.clk(clk), .cmd(cmd), .wreq(wreq));
    lbrs_top #(.DEPTH(lbrs_pkg::DEPTH_DEEP)) i_lbrs_top (.CLK_SYS(clk), .RST(rst),
        .RAM_MODE(mode), .WREQ(wreq), .RD(rd), .FF_TIMING_EDGE_INPUT(ffc), .STORAGE_ENABLE(se),
        .SET_RESET(sr), .GLOBAL_INIT(gi), .LATCH_MODE(lm), .SET_RESET_VAL(srv), .SRC_SEL_A(sa),
        .SRC_SEL_B(sb), .DIRECT_IN(din), .THIRD_GEN_INPUT(tgi), .FUNC_IN(fin),
        .FUNC_THIRD(ft), .FUNC_OUT(fout), .STORE_Q(q));
    function automatic logic pat(input logic [4:0] i, input logic s);
        return i[0] ^ i[2] ^ i[4] ^ s;
    endfunction
    task chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task put(input logic [3:0] a, b, input logic h, d0, d1, w);
        @(posedge clk);
        cmd <= '{a, b, h, d0, d1, w};
    endtask
    // Write lands two edges after launch, so idle twice before reading
    task settle;
        put(4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        put(4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    endtask
    task rd2(input logic [3:0] a, b, input logic h, ep, es);
        put(a, b, h, 1'h0, 1'h0, 1'h0);
        @(negedge clk);
        #1 chk("read", {rd.primary_read_out, rd.second_read_output}, {ep, es});
    endtask
    // Write once, then hold the addresses idle so the landing checks see it
    task hold_wr(input logic [3:0] a, b, input logic h, d0, d1, ep, es);
        put(a, b, h, d0, d1, 1'h1);
        put(a, b, h, 1'h0, 1'h0, 1'h0);
        rd2(a, b, h, ep, es);
    endtask
    task t_sp16;
        @(negedge clk) mode = lbrs_pkg::MODE_SP16;
        rd2(4'h3, 4'h0, 1'h0, 1'h0, 1'h0);
        for (int i = 0; i < 16; i++) put(i[3:0], 4'h0, 1'h0, pat(i[4:0], 1'h0), 1'h0, 1'h1);
        put(4'h0, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0);
        settle();
        for (int i = 0; i < 16; i++) rd2(i[3:0], 4'h0, 1'h0, pat(i[4:0], 1'h0), 1'h0);
        hold_wr(4'h5, 4'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        $display("test sp16 done");
    endtask
    task t_sp32;
        @(negedge clk) mode = lbrs_pkg::MODE_SP32;
        for (int i = 0; i < 32; i++) put(i[3:0], 4'h0, i[4], pat(i[4:0], 1'h1), 1'h0, 1'h1);
        settle();
        for (int i = 0; i < 32; i++) rd2(i[3:0], 4'h0, i[4], pat(i[4:0], 1'h1), 1'h0);
        hold_wr(4'h5, 4'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        $display("test sp32 done");
    endtask
    task t_pair;
        @(negedge clk) mode = lbrs_pkg::MODE_SP16X2;
        for (int i = 0; i < 16; i++)
            put(i[3:0], 4'(15 - i), 1'h0, pat(i[4:0], 1'h0), pat(5'(15 - i), 1'h1), 1'h1);
        settle();
        for (int i = 0; i < 16; i++)
            rd2(i[3:0], 4'(15 - i), 1'h0, pat(i[4:0], 1'h0), pat(5'(15 - i), 1'h1));
        hold_wr(4'h3, 4'hc, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
        $display("test pair done");
    endtask
    task t_dual;
        @(negedge clk) mode = lbrs_pkg::MODE_DP16;
        for (int i = 0; i < 16; i++) put(i[3:0], 4'(15 - i), 1'h0, i[1], 1'h0, 1'h1);
        settle();
        for (int i = 0; i < 16; i++) rd2(i[3:0], 4'(15 - i), 1'h0, i[1], ~i[1]);
        rd2(4'h6, 4'h6, 1'h0, 1'h1, 1'h1);
        hold_wr(4'h9, 4'h9, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
        // Second port reads while a write stands on the primary port
        put(4'ha, 4'h6, 1'h0, 1'h0, 1'h0, 1'h1);
        @(negedge clk);
        #1 chk("dual rw", {rd.primary_read_out, rd.second_read_output}, 2'h3);
        settle();
        rd2(4'ha, 4'ha, 1'h0, 1'h0, 1'h0);
        $display("test dual done");
    endtask
    task t_store;
        @(negedge clk) din = 1'h1;
        tgi = 1'h1;
        ft = 1'h1;
        fin = 2'h2;
        repeat (4) @(negedge clk);
        chk("store", q, 2'h1);
        chk("func", fout, 2'h2);
        tgi = 1'h0;
        repeat (4) @(negedge clk);
        chk("store", q, 2'h3);
        se = 1'h0;
        din = 1'h0;
        repeat (4) @(negedge clk);
        chk("store", q, 2'h3);
        se = 1'h1;
        sr = 1'h1;
        srv = 2'h2;
        repeat (4) @(negedge clk);
        chk("store", q, 2'h2);
        gi = 1'h1;
        repeat (4) @(negedge clk);
        chk("store", q, 2'h0);
        rd2(4'h2, 4'hd, 1'h0, 1'h1, 1'h0);
        @(negedge clk) gi = 1'h0;
        sr = 1'h0;
        lm = 1'h1;
        sb = lbrs_pkg::SRC_FUNC;
        fin = 2'h3;
        din = 1'h1;
        repeat (4) @(negedge clk);
        chk("latch", q, 2'h3);
        // Reset in mid-run clears the storage elements but never the RAM
        @(negedge clk) rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        rd2(4'h9, 4'h9, 1'h0, 1'h1, 1'h1);
        $display("test store done");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'h0;
        t_sp16();
        t_sp32();
        t_pair();
        t_dual();
        t_store();
        print_verdict();
    end
endmodule
